// >>> design/cefmb_pkg.sv
package cefmb_pkg;

  // Register offsets
  localparam logic [7:0] CEFMB_OFS_FLAGS_THERMAL_ADC = 8'h1B;
  localparam logic [7:0] CEFMB_OFS_FLAGS_CONVERTER = 8'h1C;
  localparam logic [7:0] CEFMB_OFS_MASK_BATTERY_BUS = 8'h1D;
  localparam logic [7:0] CEFMB_OFS_MASK_BUS_CURRENT = 8'h1E;

  // Values after reset
  localparam logic [7:0] CEFMB_RST_FLAGS = 8'h00;
  localparam logic [7:0] CEFMB_RST_MASK = 8'h00;
  localparam logic [7:0] CEFMB_RST_RDATA = 8'h00;

  // Implemented bits per register
  localparam logic [7:0] CEFMB_MASK1_WR_BITS = 8'hFF;
  localparam logic [7:0] CEFMB_MASK2_WR_BITS = 8'hFE;
  localparam logic [7:0] CEFMB_FLAGS2_GATE_BITS = 8'hF4;
  localparam logic [7:0] CEFMB_FLAGS5_GATE_BITS = 8'hD0;

  // Field positions, flag bank 4
  localparam int CEFMB_BIT_ADC_DONE = 7;
  localparam int CEFMB_BIT_SOFT_START_TIMEOUT = 6;
  localparam int CEFMB_BIT_TEMP_SENSE_ALARM = 5;
  localparam int CEFMB_BIT_CONNECTOR_TEMP_FAULT = 4;
  localparam int CEFMB_BIT_BATTERY_TEMP_FAULT = 3;
  localparam int CEFMB_BIT_DIE_OVERTEMP_FAULT = 2;
  localparam int CEFMB_BIT_DIE_TEMP_ALARM = 1;
  localparam int CEFMB_BIT_HOST_TIMER_EXPIRY = 0;

  // Field positions, flag bank 5
  localparam int CEFMB_BIT_REGULATOR_OK = 7;
  localparam int CEFMB_BIT_CONVERTER_RUNNING = 6;
  localparam int CEFMB_BIT_BUS_ERROR_HIGH = 4;

  // Flag cells: 0..7 are bank 4 bits, 8..10 bank 5 bits 4, 6, 7
  localparam int CEFMB_NUM_CELLS = 11;
  localparam int CEFMB_BANK4_CELLS = 8;

  // Cycles after reset release before change detection is trusted
  localparam logic [1:0] CEFMB_SETTLE_CYCLES = 2'h3;
  localparam logic [1:0] CEFMB_SETTLE_START = 2'h0;

  typedef enum logic [1:0] {
    CEFMB_ST_SETTLE = 2'b00,
    CEFMB_ST_ARMED = 2'b01
  } cefmb_arm_st_t;

endpackage

// >>> design/cefmb_flag_cell.sv
`timescale 1ns/10ps
`default_nettype none
module cefmb_flag_cell (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Status level from outside the clock domain
  input wire logic status_in,
  // Qualifier and clear from the register logic
  input wire logic arm_in,
  input wire logic clear_in,
  // Latched event flag
  output logic flag_out
);
  import cefmb_pkg::*;

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic change;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= status_in;
      sync_r <= meta_r;
    end
  end

  // Previous level keeps tracking even while disarmed, so arming later
  // never reports a change that happened long ago
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= sync_r;
    end
  end

  assign change = sync_r ^ prev_r;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flag_out <= 1'b0;
    end else if (arm_in && change) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end

endmodule // cefmb_flag_cell
`default_nettype wire

// >>> design/cefmb_top.sv
`timescale 1ns/10ps
`default_nettype none
module cefmb_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Register-reset command, one cycle pulse
  input wire logic reg_reset_cmd_in,
  // ADC mode, high while the ADC runs one-shot
  input wire logic adc_one_shot_in,
  // Status levels for flag bank 4
  input wire logic adc_done_stat_in,
  input wire logic soft_start_timeout_stat_in,
  input wire logic temp_sense_alarm_stat_in,
  input wire logic connector_temp_fault_stat_in,
  input wire logic battery_temp_fault_stat_in,
  input wire logic die_overtemp_fault_stat_in,
  input wire logic die_temp_alarm_stat_in,
  input wire logic host_timer_expiry_stat_in,
  // Status levels for flag bank 5
  input wire logic regulator_ok_stat_in,
  input wire logic converter_running_stat_in,
  input wire logic bus_error_high_stat_in,
  // Flags and masks held by neighbouring register banks
  input wire logic [7:0] prot_flags_bank1_in,
  input wire logic [7:0] prot_flags_bank2_in,
  input wire logic [7:0] thermal_adc_irq_mask_in,
  input wire logic [7:0] converter_irq_mask_in,
  // Interrupt request, active high
  output logic irq_out
);
  import cefmb_pkg::*;

  cefmb_arm_st_t arm_st_r;
  cefmb_arm_st_t arm_st_nxt;
  logic [1:0] settle_cnt_r;
  logic armed;

  logic [CEFMB_NUM_CELLS-1:0] cell_status;
  logic [CEFMB_NUM_CELLS-1:0] cell_arm;
  logic [CEFMB_NUM_CELLS-1:0] cell_clear;
  logic [CEFMB_NUM_CELLS-1:0] cell_flag;

  logic [7:0] flags_thermal_adc;
  logic [7:0] flags_converter;
  logic [7:0] interrupt_mask_battery_bus_r;
  logic [7:0] interrupt_mask_bus_current_r;
  logic [7:0] rdata_nxt;
  logic rd_flags4;
  logic rd_flags5;
  logic wr_mask1;
  logic wr_mask2;
  logic irq_nxt;

  // Arming: synchronisers start at 0 and a high status would look like a
  // change, so detection waits until the pipeline has settled
  always_comb begin
    arm_st_nxt = arm_st_r;
    unique case (arm_st_r)
      CEFMB_ST_SETTLE: begin
        if (settle_cnt_r == CEFMB_SETTLE_CYCLES) begin
          arm_st_nxt = CEFMB_ST_ARMED;
        end
      end
      CEFMB_ST_ARMED: begin
        arm_st_nxt = CEFMB_ST_ARMED;
      end
      default: begin
        arm_st_nxt = CEFMB_ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      arm_st_r <= CEFMB_ST_SETTLE;
    end else begin
      arm_st_r <= arm_st_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      settle_cnt_r <= CEFMB_SETTLE_START;
    end else if (arm_st_r == CEFMB_ST_SETTLE &&
                 settle_cnt_r != CEFMB_SETTLE_CYCLES) begin
      settle_cnt_r <= settle_cnt_r + 2'h1;
    end
  end

  assign armed = (arm_st_r == CEFMB_ST_ARMED);

  // Register strobes
  assign rd_flags4 = reg_rd_in && (reg_addr_in == CEFMB_OFS_FLAGS_THERMAL_ADC);
  assign rd_flags5 = reg_rd_in && (reg_addr_in == CEFMB_OFS_FLAGS_CONVERTER);
  assign wr_mask1 = reg_wr_in && (reg_addr_in == CEFMB_OFS_MASK_BATTERY_BUS);
  assign wr_mask2 = reg_wr_in && (reg_addr_in == CEFMB_OFS_MASK_BUS_CURRENT);

  // Status lines into cells
  assign cell_status[CEFMB_BIT_ADC_DONE] = adc_done_stat_in;
  assign cell_status[CEFMB_BIT_SOFT_START_TIMEOUT] =
    soft_start_timeout_stat_in;
  assign cell_status[CEFMB_BIT_TEMP_SENSE_ALARM] =
    temp_sense_alarm_stat_in;
  assign cell_status[CEFMB_BIT_CONNECTOR_TEMP_FAULT] =
    connector_temp_fault_stat_in;
  assign cell_status[CEFMB_BIT_BATTERY_TEMP_FAULT] =
    battery_temp_fault_stat_in;
  assign cell_status[CEFMB_BIT_DIE_OVERTEMP_FAULT] =
    die_overtemp_fault_stat_in;
  assign cell_status[CEFMB_BIT_DIE_TEMP_ALARM] =
    die_temp_alarm_stat_in;
  assign cell_status[CEFMB_BIT_HOST_TIMER_EXPIRY] =
    host_timer_expiry_stat_in;
  assign cell_status[8] = bus_error_high_stat_in;
  assign cell_status[9] = converter_running_stat_in;
  assign cell_status[10] = regulator_ok_stat_in;

  // Cells clear on a read of their own bank; a change in the same cycle
  // wins inside the cell and is seen on the next read
  genvar gi;
  generate
    for (gi = 0; gi < CEFMB_NUM_CELLS; gi = gi + 1) begin : g_cell
      if (gi == CEFMB_BIT_ADC_DONE) begin : g_adc
        assign cell_arm[gi] = armed && adc_one_shot_in;
      end else begin : g_plain
        assign cell_arm[gi] = armed;
      end
      if (gi < CEFMB_BANK4_CELLS) begin : g_b4
        assign cell_clear[gi] = rd_flags4;
      end else begin : g_b5
        assign cell_clear[gi] = rd_flags5;
      end
      cefmb_flag_cell u_cell (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .status_in(cell_status[gi]),
        .arm_in(cell_arm[gi]),
        .clear_in(cell_clear[gi]),
        .flag_out(cell_flag[gi])
      );
    end
  endgenerate

  assign flags_thermal_adc = cell_flag[CEFMB_BANK4_CELLS-1:0];
  // Reserved bits tie to zero
  assign flags_converter = {cell_flag[10], cell_flag[9], 1'b0,
                            cell_flag[8], 4'h0};

  // Mask registers; the reset command outranks a write in the same cycle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      interrupt_mask_battery_bus_r <= CEFMB_RST_MASK;
    end else if (reg_reset_cmd_in) begin
      interrupt_mask_battery_bus_r <= CEFMB_RST_MASK;
    end else if (wr_mask1) begin
      interrupt_mask_battery_bus_r <=
        reg_wdata_in & CEFMB_MASK1_WR_BITS;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      interrupt_mask_bus_current_r <= CEFMB_RST_MASK;
    end else if (reg_reset_cmd_in) begin
      interrupt_mask_bus_current_r <= CEFMB_RST_MASK;
    end else if (wr_mask2) begin
      // Bits 3 and 1 are kept as storage, bit 0 is never stored
      interrupt_mask_bus_current_r <=
        reg_wdata_in & CEFMB_MASK2_WR_BITS;
    end
  end

  // Read data; flag registers ignore writes
  always_comb begin
    rdata_nxt = CEFMB_RST_RDATA;
    unique case (reg_addr_in)
      CEFMB_OFS_FLAGS_THERMAL_ADC: rdata_nxt = flags_thermal_adc;
      CEFMB_OFS_FLAGS_CONVERTER: rdata_nxt = flags_converter;
      CEFMB_OFS_MASK_BATTERY_BUS: rdata_nxt = interrupt_mask_battery_bus_r;
      CEFMB_OFS_MASK_BUS_CURRENT: rdata_nxt = interrupt_mask_bus_current_r;
      default: rdata_nxt = CEFMB_RST_RDATA;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= CEFMB_RST_RDATA;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_nxt;
    end else begin
      reg_rdata_out <= CEFMB_RST_RDATA;
    end
  end

  // Interrupt; registered, so it follows the flags by one cycle
  assign irq_nxt =
    (|(prot_flags_bank1_in & ~interrupt_mask_battery_bus_r)) ||
    (|(prot_flags_bank2_in & ~interrupt_mask_bus_current_r &
       CEFMB_FLAGS2_GATE_BITS)) ||
    (|(flags_thermal_adc & ~thermal_adc_irq_mask_in)) ||
    (|(flags_converter & ~converter_irq_mask_in &
       CEFMB_FLAGS5_GATE_BITS));

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_nxt;
    end
  end

endmodule // cefmb_top
`default_nettype wire

// >>> tb/cefmb_checker.sv
`timescale 1ns/10ps
`default_nettype none
module cefmb_checker (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_reset_cmd_in,
  // Neighbour flags, masks and interrupt
  input wire logic [7:0] prot_flags_bank1_in,
  input wire logic [7:0] prot_flags_bank2_in,
  input wire logic [7:0] thermal_adc_irq_mask_in,
  input wire logic [7:0] converter_irq_mask_in,
  input wire logic irq_out
);
  logic mapped;
  logic quiet;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  assign mapped = reg_addr_in inside {8'h1B, 8'h1C, 8'h1D, 8'h1E};
  // Nothing outside can raise the request while this holds
  assign quiet = prot_flags_bank1_in == 8'h00 &&
    (prot_flags_bank2_in & 8'hF4) == 8'h00 &&
    thermal_adc_irq_mask_in == 8'hFF && converter_irq_mask_in == 8'hFF;
  rdata_idle_a: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00) else $error("idle data");
  unmapped_rd_a: assert property (
    reg_rd_in && !mapped |=> reg_rdata_out == 8'h00) else $error("unmapped");
  flag5_rsvd_a: assert property (
    reg_rd_in && reg_addr_in == 8'h1C |=> (reg_rdata_out & 8'h2F) == 8'h00)
    else $error("reserved flag bits");
  mask2_bit0_a: assert property (
    reg_rd_in && reg_addr_in == 8'h1E |=> !reg_rdata_out[0])
    else $error("mask bit 0");
  mask_rdback_a: assert property (
    reg_wr_in && reg_addr_in == 8'h1D && !reg_reset_cmd_in ##1
    !reg_wr_in && !reg_reset_cmd_in ##1 reg_rd_in && reg_addr_in == 8'h1D
    |=> reg_rdata_out == $past(reg_wdata_in, 3)) else $error("readback");
  mask_clear_a: assert property (
    reg_reset_cmd_in ##1 !reg_wr_in ##1
    reg_rd_in && reg_addr_in inside {8'h1D, 8'h1E}
    |=> reg_rdata_out == 8'h00) else $error("mask clear");
  irq_unmask_a: assert property (
    reg_reset_cmd_in ##1 prot_flags_bank1_in != 8'h00 && !reg_wr_in
    |=> irq_out) else $error("irq missing");
  irq_quiet_a: assert property (
    quiet |=> !irq_out) else $error("irq not blocked");
  cover property (reg_rd_in && reg_addr_in == 8'h1B ##1 reg_rdata_out != 8'h00);
  cover property ($rose(irq_out));
  cover property ($fell(irq_out));
endmodule // cefmb_checker
bind cefmb_top cefmb_checker chk_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .reg_reset_cmd_in(reg_reset_cmd_in),
  .prot_flags_bank1_in(prot_flags_bank1_in),
  .prot_flags_bank2_in(prot_flags_bank2_in), .irq_out(irq_out),
  .thermal_adc_irq_mask_in(thermal_adc_irq_mask_in),
  .converter_irq_mask_in(converter_irq_mask_in));
`default_nettype wire

// >>> tb/cefmb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cefmb_host_model (
  // Clock
  input wire logic clk_in,
  // Register port towards the block
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [7:0] rdata_in
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    // Released data is inverted so a stale value never passes for live
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule // cefmb_host_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic cmd = 1'b0;
  logic one_shot = 1'b1;
  logic [7:0] s4 = 8'h00;
  logic [2:0] s5 = 3'h0;
  logic [7:0] fb1 = 8'h00;
  logic [7:0] fb2 = 8'h00;
  logic [7:0] m4 = 8'h00;
  logic [7:0] m5 = 8'h00;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, irq;
  int mismatches = 0;
  int comparisons = 0;
  cefmb_host_model host (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
  cefmb_top uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata),
    .reg_reset_cmd_in(cmd), .adc_one_shot_in(one_shot),
    .adc_done_stat_in(s4[7]), .soft_start_timeout_stat_in(s4[6]),
    .temp_sense_alarm_stat_in(s4[5]), .connector_temp_fault_stat_in(s4[4]),
    .battery_temp_fault_stat_in(s4[3]), .die_overtemp_fault_stat_in(s4[2]),
    .die_temp_alarm_stat_in(s4[1]), .host_timer_expiry_stat_in(s4[0]),
    .regulator_ok_stat_in(s5[2]), .converter_running_stat_in(s5[1]),
    .bus_error_high_stat_in(s5[0]), .prot_flags_bank1_in(fb1),
    .prot_flags_bank2_in(fb2), .thermal_adc_irq_mask_in(m4),
    .converter_irq_mask_in(m5), .irq_out(irq));
  initial forever #20 clk_in = ~clk_in;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t ns: got %h, want %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk(d, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic ichk(input logic e);
    wt(2);
    chk({7'h00, irq}, {7'h00, e});
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // A full run takes well under 1000 cycles
  initial begin
    #60000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    for (int a = 8'h1B; a <= 8'h1F; a++) rchk(8'(a), 8'h00);
    $display("test reset values done");
    host.wr(8'h1D, 8'hFF);
    rchk(8'h1D, 8'hFF);
    host.wr(8'h1E, 8'hFF);
    rchk(8'h1E, 8'hFE);
    host.wr(8'h1B, 8'hFF);
    rchk(8'h1B, 8'h00);
    @(posedge clk_in);
    cmd <= 1'b1;
    fb1 <= 8'h01;
    @(posedge clk_in);
    cmd <= 1'b0;
    rchk(8'h1D, 8'h00);
    rchk(8'h1E, 8'h00);
    ichk(1'b1);
    $display("test mask access done");
    @(posedge clk_in);
    fb1 <= 8'h00;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      s4[i] <= ~s4[i];
      wt(6);
      chk({7'h00, irq}, 8'h01);
      rchk(8'h1B, 8'h01 << i);
      rchk(8'h1B, 8'h00);
      ichk(1'b0);
    end
    @(posedge clk_in);
    one_shot <= 1'b0;
    s4[7] <= ~s4[7];
    wt(6);
    rchk(8'h1B, 8'h00);
    @(posedge clk_in);
    s5 <= 3'h7;
    wt(6);
    rchk(8'h1C, 8'hD0);
    rchk(8'h1C, 8'h00);
    // Change lands in the read cycle: that read shows 0, the next one 1
    @(posedge clk_in);
    s4[0] <= ~s4[0];
    @(posedge clk_in);
    rchk(8'h1B, 8'h00);
    rchk(8'h1B, 8'h01);
    $display("test event flags done");
    @(posedge clk_in);
    m4 <= 8'hFF;
    m5 <= 8'hFF;
    fb1 <= 8'h80;
    host.wr(8'h1D, 8'h80);
    ichk(1'b0);
    // A latched bank 4 flag under a set mask must stay off the request
    @(posedge clk_in);
    s4[0] <= ~s4[0];
    wt(6);
    chk({7'h00, irq}, 8'h00);
    rchk(8'h1B, 8'h01);
    host.wr(8'h1D, 8'h7F);
    ichk(1'b1);
    @(posedge clk_in);
    fb1 <= 8'h00;
    fb2 <= 8'h0B;
    ichk(1'b0);
    @(posedge clk_in);
    fb2 <= 8'h04;
    host.wr(8'h1E, 8'h04);
    ichk(1'b0);
    host.wr(8'h1E, 8'hFB);
    ichk(1'b1);
    $display("test interrupt gating done");
    finish_test;
  end
endmodule // testbench
`default_nettype wire
